// File: src/sphc_defs.vh
// constants for the serial port and handshake control block
// assumes one 250 MHz clock and a synchronous active-high reset
`ifndef SPHC_DEFS_VH
`define SPHC_DEFS_VH
`define SPHC_CLK_HZ 250000000
`define SPHC_RATE_0 300
`define SPHC_RATE_1 600
`define SPHC_RATE_2 1200
`define SPHC_RATE_3 2400
`define SPHC_RATE_4 4800
`define SPHC_RATE_5 9600
`define SPHC_RATE_6 19200
`define SPHC_RATE_7 38400
`define SPHC_CFG_RATE_SEL 3'h5
`define SPHC_DL_7 2'h0
`define SPHC_DL_8 2'h1
`define SPHC_DL_9 2'h2
`define SPHC_PAR_NONE 2'h0
`define SPHC_PAR_EVEN 2'h1
`define SPHC_PAR_ODD 2'h2
`define SPHC_CTS_TRAD 1'b0
`define SPHC_CTS_BUF 1'b1
`define SPHC_CD_THRESH 2'h0
`define SPHC_CD_DATA 2'h1
`define SPHC_RTS_IGNORE 2'h0
`define SPHC_RTS_FLOW 2'h1
`define SPHC_RTS_RXCTL 2'h2
`define SPHC_TXBUF_DEPTH 1024
`define SPHC_TXBUF_AW 10
`define SPHC_RXBUF_DEPTH 16
`define SPHC_RXBUF_AW 4
`define SPHC_CTS_MARGIN 11'h010
`define SPHC_KEY_SAVE 8'h45
`define SPHC_KEY_QUIT 8'h51
`define SPHC_KEY_RESTORE 8'h41
`define SPHC_KEY_YES 8'h59
`define SPHC_CASE_MASK 8'hdf
`endif

// File: src/sphc_serial_port.v
// terminal serial port with handshake lines, transmit buffer and setup menu keys
// assumes pins are asynchronous to clock_i; radio side logic shares clock_i
`timescale 1ns/100ps
`include "sphc_defs.vh"

module sphc_fifo #(
  parameter WIDTH = 9,
  parameter DEPTH = 16,
  parameter AW = 4
) (
  input wire clock_i,
  input wire srst_i,
  input wire flush_i,
  input wire [WIDTH-1:0] wr_data_i,
  input wire wr_valid_i,
  output wire wr_ready_o,
  output wire [WIDTH-1:0] rd_data_o,
  output wire rd_valid_o,
  input wire rd_ready_i,
  output wire [AW:0] level_o
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wr_ptr;
  reg [AW-1:0] rd_ptr;
  reg [AW:0] level;
  wire do_wr;
  wire do_rd;

  assign wr_ready_o = (level != DEPTH);
  assign rd_valid_o = (level != {(AW+1){1'b0}});
  assign rd_data_o = mem[rd_ptr];
  assign level_o = level;
  assign do_wr = wr_valid_i & wr_ready_o;
  assign do_rd = rd_ready_i & rd_valid_o;

  always @(posedge clock_i) begin
    if (do_wr) begin
      mem[wr_ptr] <= wr_data_i;
    end
  end

  always @(posedge clock_i) begin
    if (srst_i || flush_i) begin
      wr_ptr <= {AW{1'b0}};
      rd_ptr <= {AW{1'b0}};
      level <= {(AW+1){1'b0}};
    end else begin
      if (do_wr) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (do_rd) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
      if (do_wr && !do_rd) begin
        level <= level + 1'b1;
      end else if (do_rd && !do_wr) begin
        level <= level - 1'b1;
      end
    end
  end
endmodule

module sphc_serial_port #(
  parameter CLK_HZ = `SPHC_CLK_HZ
) (
  input wire clock_i,
  input wire srst_i,
  input wire serial_rx_i,
  output wire serial_tx_o,
  output reg cts_o,
  output reg cd_o,
  input wire rts_i,
  input wire cfg_strobe_n_i,
  input wire [2:0] rate_sel_i,
  input wire [1:0] data_len_i,
  input wire [1:0] parity_i,
  input wire two_stop_i,
  input wire cts_mode_i,
  input wire [1:0] cd_mode_i,
  input wire [1:0] rts_mode_i,
  output wire [8:0] radio_tx_data_o,
  output wire radio_tx_valid_o,
  input wire radio_tx_ready_i,
  input wire [8:0] radio_rx_data_i,
  input wire radio_rx_valid_i,
  output wire radio_rx_ready_o,
  input wire radio_receiving_i,
  input wire radio_transmitting_i,
  input wire radio_above_thresh_i,
  input wire radio_valid_data_i,
  input wire tx_pause_i,
  input wire serial_faster_i,
  output reg rx_abort_o,
  output wire config_mode_o,
  output reg framing_err_o,
  output reg parity_err_o,
  output reg tx_overflow_o,
  output reg save_o,
  output reg quit_o,
  output reg restore_o
);
  localparam R_IDLE = 2'd0;
  localparam R_START = 2'd1;
  localparam R_BITS = 2'd2;
  localparam M_IDLE = 2'd0;
  localparam M_ASK1 = 2'd1;
  localparam M_ASK2 = 2'd2;

  // slowest rate at the full clock still fits twenty bits
  function [19:0] bit_cycles;
    input [2:0] sel;
    reg [31:0] q;
    begin
      case (sel)
        3'h0: q = CLK_HZ / `SPHC_RATE_0;
        3'h1: q = CLK_HZ / `SPHC_RATE_1;
        3'h2: q = CLK_HZ / `SPHC_RATE_2;
        3'h3: q = CLK_HZ / `SPHC_RATE_3;
        3'h4: q = CLK_HZ / `SPHC_RATE_4;
        3'h5: q = CLK_HZ / `SPHC_RATE_5;
        3'h6: q = CLK_HZ / `SPHC_RATE_6;
        default: q = CLK_HZ / `SPHC_RATE_7;
      endcase
      bit_cycles = q[19:0];
    end
  endfunction

  // three-stage synchronisers; value moves only when stages two and three agree
  reg [2:0] pin_s1;
  reg [2:0] pin_s2;
  reg [2:0] pin_s3;
  reg [2:0] pin_q;
  wire [2:0] pin_raw;
  assign pin_raw = {cfg_strobe_n_i, rts_i, serial_rx_i};
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi = gi + 1) begin : g_sync
      always @(posedge clock_i) begin
        if (srst_i) begin
          pin_s1[gi] <= 1'b1;
          pin_s2[gi] <= 1'b1;
          pin_s3[gi] <= 1'b1;
          pin_q[gi] <= 1'b1;
        end else begin
          pin_s1[gi] <= pin_raw[gi];
          pin_s2[gi] <= pin_s1[gi];
          pin_s3[gi] <= pin_s2[gi];
          if (pin_s2[gi] == pin_s3[gi]) begin
            pin_q[gi] <= pin_s3[gi];
          end
        end
      end
    end
  endgenerate
  wire rx_line = pin_q[0];
  wire rts_on = pin_q[1];
  wire cfg_mode = ~pin_q[2];
  assign config_mode_o = cfg_mode;

  // effective line format; setup mode forces 9600 8N1
  wire [2:0] eff_rate = cfg_mode ? `SPHC_CFG_RATE_SEL : rate_sel_i;
  wire [1:0] eff_dl = cfg_mode ? `SPHC_DL_8 : data_len_i;
  wire eff_stop2 = cfg_mode ? 1'b0 : two_stop_i;
  wire [3:0] n_data = (eff_dl == `SPHC_DL_7) ? 4'd7 :
                      (eff_dl == `SPHC_DL_9) ? 4'd9 : 4'd8;
  wire par_on = !cfg_mode && (parity_i != `SPHC_PAR_NONE) && (n_data != 4'd9);
  wire par_odd = (parity_i == `SPHC_PAR_ODD);
  wire [19:0] bit_cyc = bit_cycles(eff_rate);
  wire [9:0] data_mask = (n_data == 4'd7) ? 10'h07f : (n_data == 4'd8) ? 10'h0ff : 10'h1ff;

  // transmit toward terminal, fed from the received-radio buffer
  wire [8:0] rb_data;
  wire rb_valid;
  wire rb_ready;
  reg [11:0] tx_shift;
  reg [3:0] tx_left;
  reg [19:0] tx_cnt;
  reg tx_busy;
  reg [11:0] next_frame;
  reg [8:0] tx_d;
  integer k;
  wire tx_gate = !cfg_mode && (rts_mode_i != `SPHC_RTS_FLOW || rts_on);
  assign rb_ready = !tx_busy && tx_gate;
  assign serial_tx_o = tx_shift[0];

  always @* begin
    tx_d = rb_data & data_mask[8:0];
    next_frame = 12'hfff;
    next_frame[0] = 1'b0;
    for (k = 0; k < 9; k = k + 1) begin
      if (k < n_data) begin
        next_frame[k+1] = tx_d[k];
      end
    end
    if (par_on) begin
      next_frame[n_data+1] = (^tx_d) ^ par_odd;
    end
  end

  always @(posedge clock_i) begin
    if (srst_i) begin
      tx_shift <= 12'hfff;
      tx_left <= 4'h0;
      tx_cnt <= 20'h0_0000;
      tx_busy <= 1'b0;
    end else if (!tx_busy) begin
      if (rb_valid && tx_gate) begin
        tx_shift <= next_frame;
        tx_left <= n_data + {3'b000, par_on} + {3'b000, eff_stop2} + 4'd2;
        tx_cnt <= bit_cyc - 20'h0_0001;
        tx_busy <= 1'b1;
      end
    end else if (tx_cnt == 20'h0_0000) begin
      tx_cnt <= bit_cyc - 20'h0_0001;
      tx_shift <= {1'b1, tx_shift[11:1]};
      tx_left <= tx_left - 4'h1;
      if (tx_left == 4'h1) begin
        tx_busy <= 1'b0;
      end
    end else begin
      tx_cnt <= tx_cnt - 20'h0_0001;
    end
  end

  // receive from terminal; sample mid-bit after a half-bit start check
  reg [1:0] rx_state;
  reg [19:0] rx_cnt;
  reg [3:0] rx_left;
  reg [10:0] rx_shift;
  reg [8:0] rx_char;
  reg rx_stb;
  wire [3:0] rx_n = n_data + {3'b000, par_on} + 4'd1;
  wire [10:0] rx_full = {rx_line, rx_shift[10:1]};
  wire [10:0] rx_al = rx_full >> (4'd11 - rx_n);
  wire [8:0] rx_d = rx_al[8:0] & data_mask[8:0];

  always @(posedge clock_i) begin
    if (srst_i) begin
      rx_state <= R_IDLE;
      rx_cnt <= 20'h0_0000;
      rx_left <= 4'h0;
      rx_shift <= 11'h000;
      rx_char <= 9'h000;
      rx_stb <= 1'b0;
      framing_err_o <= 1'b0;
      parity_err_o <= 1'b0;
    end else begin
      rx_stb <= 1'b0;
      framing_err_o <= 1'b0;
      parity_err_o <= 1'b0;
      case (rx_state)
        R_IDLE: begin
          if (!rx_line) begin
            rx_state <= R_START;
            rx_cnt <= {1'b0, bit_cyc[19:1]};
          end
        end
        R_START: begin
          if (rx_cnt != 20'h0_0000) begin
            rx_cnt <= rx_cnt - 20'h0_0001;
          end else if (!rx_line) begin
            rx_state <= R_BITS;
            rx_cnt <= bit_cyc - 20'h0_0001;
            rx_left <= rx_n;
          end else begin
            rx_state <= R_IDLE;
          end
        end
        R_BITS: begin
          if (rx_cnt != 20'h0_0000) begin
            rx_cnt <= rx_cnt - 20'h0_0001;
          end else begin
            rx_cnt <= bit_cyc - 20'h0_0001;
            rx_shift <= rx_full;
            rx_left <= rx_left - 4'h1;
            if (rx_left == 4'h1) begin
              rx_state <= R_IDLE;
              if (!rx_al[rx_n-4'd1]) begin
                framing_err_o <= 1'b1;
              end else begin
                rx_char <= rx_d;
                rx_stb <= 1'b1;
                if (par_on && ((^rx_d) ^ par_odd ^ rx_al[n_data])) begin
                  parity_err_o <= 1'b1;
                end
              end
            end
          end
        end
        default: rx_state <= R_IDLE;
      endcase
    end
  end

  // transmit buffer toward the radio; overfill flushes and restarts
  wire tb_ready;
  wire [10:0] tb_level;
  wire tb_push = rx_stb && !cfg_mode;
  wire tb_flush = tb_push && !tb_ready;
  sphc_fifo #(
    .WIDTH(9),
    .DEPTH(`SPHC_TXBUF_DEPTH),
    .AW(`SPHC_TXBUF_AW)
  ) u_txbuf (
    .clock_i(clock_i),
    .srst_i(srst_i),
    .flush_i(tb_flush),
    .wr_data_i(rx_char),
    .wr_valid_i(tb_push),
    .wr_ready_o(tb_ready),
    .rd_data_o(radio_tx_data_o),
    .rd_valid_o(radio_tx_valid_o),
    .rd_ready_i(radio_tx_ready_i),
    .level_o(tb_level)
  );

  // radio data held here while, in RTS flow mode, the terminal holds request-to-send off
  wire [4:0] rb_level;
  sphc_fifo #(
    .WIDTH(9),
    .DEPTH(`SPHC_RXBUF_DEPTH),
    .AW(`SPHC_RXBUF_AW)
  ) u_rxbuf (
    .clock_i(clock_i),
    .srst_i(srst_i),
    .flush_i(1'b0),
    .wr_data_i(radio_rx_data_i),
    .wr_valid_i(radio_rx_valid_i),
    .wr_ready_o(radio_rx_ready_o),
    .rd_data_o(rb_data),
    .rd_valid_o(rb_valid),
    .rd_ready_i(rb_ready),
    .level_o(rb_level)
  );

  // margin leaves room for characters still arriving after the drop
  wire near_full = (tb_level >= (11'd1024 - `SPHC_CTS_MARGIN));
  reg pause_hold;

  always @(posedge clock_i) begin
    if (srst_i) begin
      pause_hold <= 1'b0;
      cts_o <= 1'b0;
      cd_o <= 1'b0;
      rx_abort_o <= 1'b0;
      tx_overflow_o <= 1'b0;
    end else begin
      tx_overflow_o <= tb_flush;
      // a new pause wins over the release in the same cycle
      if (tx_pause_i) begin
        pause_hold <= 1'b1;
      end else if (!radio_transmitting_i && !radio_tx_valid_o) begin
        pause_hold <= 1'b0;
      end
      if (cts_mode_i == `SPHC_CTS_BUF) begin
        cts_o <= !near_full;
      end else begin
        cts_o <= !(radio_receiving_i || pause_hold || tx_pause_i ||
                   (serial_faster_i && near_full));
      end
      case (cd_mode_i)
        `SPHC_CD_THRESH: cd_o <= radio_above_thresh_i || radio_transmitting_i;
        `SPHC_CD_DATA: cd_o <= radio_valid_data_i;
        default: cd_o <= 1'b1;
      endcase
      case (rts_mode_i)
        `SPHC_RTS_RXCTL: rx_abort_o <= !rts_on;
        default: rx_abort_o <= 1'b0;
      endcase
    end
  end

  // setup menu keys, case-insensitive
  reg [1:0] menu_state;
  wire [7:0] key = rx_char[7:0] & `SPHC_CASE_MASK;
  wire key_stb = rx_stb && cfg_mode;

  always @(posedge clock_i) begin
    if (srst_i) begin
      menu_state <= M_IDLE;
      save_o <= 1'b0;
      quit_o <= 1'b0;
      restore_o <= 1'b0;
    end else begin
      save_o <= 1'b0;
      quit_o <= 1'b0;
      restore_o <= 1'b0;
      if (!cfg_mode) begin
        menu_state <= M_IDLE;
      end else if (key_stb) begin
        case (menu_state)
          M_IDLE: begin
            if (key == `SPHC_KEY_SAVE) begin
              save_o <= 1'b1;
            end else if (key == `SPHC_KEY_QUIT) begin
              quit_o <= 1'b1;
            end else if (key == `SPHC_KEY_RESTORE) begin
              menu_state <= M_ASK1;
            end
          end
          M_ASK1: begin
            menu_state <= (key == `SPHC_KEY_YES) ? M_ASK2 : M_IDLE;
          end
          M_ASK2: begin
            menu_state <= M_IDLE;
            if (key == `SPHC_KEY_YES) begin
              restore_o <= 1'b1;
            end
          end
          default: menu_state <= M_IDLE;
        endcase
      end
    end
  end
endmodule

// File: verif/sphc_term.sv
// terminal model: drives the modem receive pin, samples the modem transmit pin
// assumes the bench gives bit lengths in clock cycles
`timescale 1ns/100ps
module sphc_term (
  input wire clock_i,
  input wire line_i,
  output reg line_o
);
  initial line_o = 1'b1;
  task send(input [11:0] f, input integer n, input integer b);
    integer i;
    begin
      for (i = 0; i < n; i = i + 1) begin
        line_o <= f[i];
        repeat (b) @(posedge clock_i);
      end
      line_o <= 1'b1;
      @(posedge clock_i);
    end
  endtask
  // stops at mid stop bit so a back-to-back start is not missed
  task recv(input integer b, input integer n, input integer lim, output [11:0] f);
    integer i;
    begin
      f = 12'hfff;
      i = 0;
      while (line_i && i < lim) begin
        @(posedge clock_i);
        i = i + 1;
      end
      if (!line_i) begin
        repeat (b / 2) @(posedge clock_i);
        for (i = 0; i < n; i = i + 1) begin
          f[i] = line_i;
          if (i < n - 1) repeat (b) @(posedge clock_i);
        end
      end
    end
  endtask
endmodule

// File: verif/sphc_serial_port_chk.sv
// assertions on the pins and handshake lines of the serial port
// assumes binding into sphc_serial_port, one clock, sync reset
`timescale 1ns/100ps
module sphc_chk (
  input wire clock_i,
  input wire srst_i,
  input wire serial_tx_o,
  input wire cts_o,
  input wire cd_o,
  input wire rts_i,
  input wire cfg_strobe_n_i,
  input wire cts_mode_i,
  input wire [1:0] cd_mode_i,
  input wire [1:0] rts_mode_i,
  input wire radio_tx_valid_o,
  input wire radio_receiving_i,
  input wire radio_transmitting_i,
  input wire radio_above_thresh_i,
  input wire radio_valid_data_i,
  input wire tx_pause_i,
  input wire rx_abort_o,
  input wire config_mode_o,
  input wire save_o,
  input wire quit_o,
  input wire restore_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (srst_i);
  property p_cd_thr;
    cd_mode_i == 2'h0 |=> cd_o == $past(radio_above_thresh_i | radio_transmitting_i);
  endproperty
  a_cd_thr: assert property (p_cd_thr) else $error("cd threshold");
  property p_cd_data;
    cd_mode_i == 2'h1 |=> cd_o == $past(radio_valid_data_i);
  endproperty
  a_cd_data: assert property (p_cd_data) else $error("cd data");
  property p_cd_on;
    cd_mode_i[1] |=> cd_o;
  endproperty
  a_cd_on: assert property (p_cd_on) else $error("cd always");
  property p_cts_rx;
    !cts_mode_i && radio_receiving_i |=> !cts_o;
  endproperty
  a_cts_rx: assert property (p_cts_rx) else $error("cts reception");
  property p_cts_pause;
    !cts_mode_i && tx_pause_i |=> !cts_o;
  endproperty
  a_cts_pause: assert property (p_cts_pause) else $error("cts pause");
  property p_cts_buf;
    cts_mode_i && !radio_tx_valid_o |=> cts_o;
  endproperty
  a_cts_buf: assert property (p_cts_buf) else $error("cts buffer");
  property p_abort;
    (rts_mode_i == 2'h2 && !rts_i) [*6] |=> rx_abort_o;
  endproperty
  a_abort: assert property (p_abort) else $error("abort");
  property p_rts_ign;
    rts_mode_i == 2'h0 |=> !rx_abort_o;
  endproperty
  a_rts_ign: assert property (p_rts_ign) else $error("rts ignored");
  property p_cfg;
    (!cfg_strobe_n_i) [*6] |-> config_mode_o;
  endproperty
  a_cfg: assert property (p_cfg) else $error("setup entry");
  property p_bit;
    $fell(serial_tx_o) |-> !serial_tx_o [*8];
  endproperty
  a_bit: assert property (p_bit) else $error("start bit");
  property p_menu;
    (save_o || quit_o || restore_o) |-> config_mode_o ##1 !(save_o || quit_o || restore_o);
  endproperty
  a_menu: assert property (p_menu) else $error("menu pulse");
endmodule
bind sphc_serial_port sphc_chk u_chk (.*);

// File: verif/sphc_serial_port_tb.sv
// self-checking bench for the terminal serial port block
// assumes a lowered CLK_HZ: 100 cycles a bit at 38400, 400 at 9600
`timescale 1ns/100ps
module sphc_serial_port_tb;
  reg clock_i = 1'b0, srst_i = 1'b1, rts_i = 1'b1, cfg_strobe_n_i = 1'b1, two_stop_i = 1'b0;
  reg cts_mode_i = 1'b0, radio_tx_ready_i = 1'b0, radio_rx_valid_i = 1'b0;
  reg radio_receiving_i = 1'b0, radio_transmitting_i = 1'b0, radio_above_thresh_i = 1'b0;
  reg radio_valid_data_i = 1'b0, tx_pause_i = 1'b0, serial_faster_i = 1'b0;
  reg [2:0] rate_sel_i = 3'h7;
  reg [1:0] data_len_i = 2'h1, parity_i = 2'h0, cd_mode_i = 2'h0, rts_mode_i = 2'h0;
  reg [8:0] radio_rx_data_i = 9'h000;
  reg [11:0] n_par = 12'h000, n_frm = 12'h000, n_menu = 12'h000;
  integer n_errors = 0, cmp_count = 0;
  wire serial_rx_i, serial_tx_o, cts_o, cd_o, radio_tx_valid_o, radio_rx_ready_o, rx_abort_o;
  wire config_mode_o, framing_err_o, parity_err_o, tx_overflow_o, save_o, quit_o, restore_o;
  wire [8:0] radio_tx_data_o;
  sphc_serial_port #(.CLK_HZ(3840000)) uut (.*);
  sphc_term term (.clock_i(clock_i), .line_i(serial_tx_o), .line_o(serial_rx_i));
  initial forever #2 clock_i = ~clock_i;
  // menu pulses packed so one compare shows which key misfired
  always @(posedge clock_i) begin
    n_par <= n_par + {11'h000, parity_err_o};
    n_frm <= n_frm + {11'h000, framing_err_o};
    n_menu <= n_menu + {restore_o, 3'h0, quit_o, 3'h0, save_o};
  end
  task chk(input string what, input [11:0] e, input [11:0] g);
    begin
      cmp_count = cmp_count + 1;
      if (g !== e) begin
        n_errors = n_errors + 1;
        $display("ERROR %0s expected %h seen %h", what, e, g);
      end
    end
  endtask
  function [11:0] frame(input [8:0] d, input integer dl, input [1:0] par, input two);
    integer i;
    reg p;
    begin
      frame = 12'hfff;
      frame[0] = 1'b0;
      p = (par == 2'h2);
      for (i = 0; i < dl; i = i + 1) begin
        frame[i + 1] = d[i];
        p = p ^ d[i];
      end
      if (par != 2'h0) frame[dl + 1] = p;
    end
  endfunction
  task push(input [8:0] d, output ok);
    integer i;
    begin
      @(posedge clock_i);
      radio_rx_data_i <= d;
      radio_rx_valid_i <= 1'b1;
      i = 0;
      do begin
        @(posedge clock_i);
        i = i + 1;
      end while (!radio_rx_ready_o && i < 20);
      ok = radio_rx_ready_o;
      radio_rx_valid_i <= 1'b0;
    end
  endtask
  task out_char(input [8:0] d, input integer dl, input [1:0] par, input two, input integer b);
    reg [11:0] f;
    reg ok;
    begin
      fork
        push(d, ok);
        term.recv(b, 2 + dl + (par != 2'h0) + two, 4 * b, f);
      join
      chk("tx frame", frame(d, dl, par, two), f);
    end
  endtask
  task in_char(input [11:0] f);
    integer i;
    begin
      term.send(f, 11, 100);
      i = 0;
      while (!radio_tx_valid_o && i < 60) begin
        @(posedge clock_i);
        i = i + 1;
      end
    end
  endtask
  task t_formats;
    integer c, p;
    begin
      for (c = 0; c < 3; c = c + 1)
        for (p = 0; p < 3; p = p + 1) begin
          @(posedge clock_i);
          data_len_i <= c[1:0];
          parity_i <= p[1:0];
          two_stop_i <= c[0] ^ p[0];
          repeat (2) @(posedge clock_i);
          out_char(9'h1cc ^ p[8:0], 7 + c, c == 2 ? 2'h0 : p[1:0], c[0] ^ p[0], 100);
        end
      $display("formats done");
    end
  endtask
  task t_rates;
    integer r;
    begin
      @(posedge clock_i);
      data_len_i <= 2'h1;
      parity_i <= 2'h1;
      two_stop_i <= 1'b0;
      for (r = 5; r < 8; r = r + 1) begin
        @(posedge clock_i);
        rate_sel_i <= r[2:0];
        repeat (2) @(posedge clock_i);
        out_char(9'h0a5, 8, 2'h1, 1'b0, 400 >> (r - 5));
      end
      $display("rates done");
    end
  endtask
  task t_in;
    reg [11:0] f;
    begin
      f = frame(9'h05a, 8, 2'h1, 1'b0);
      in_char(f);
      chk("rx data", 12'h05a, {3'h0, radio_tx_data_o});
      radio_tx_ready_i <= 1'b1;
      @(posedge clock_i);
      radio_tx_ready_i <= 1'b0;
      in_char(f ^ 12'h200);
      chk("parity err", 12'h001, n_par);
      chk("kept data", 12'h05a, {3'h0, radio_tx_data_o});
      radio_tx_ready_i <= 1'b1;
      @(posedge clock_i);
      radio_tx_ready_i <= 1'b0;
      in_char(f & 12'hbff);
      chk("framing err", 12'h001, n_frm);
      chk("dropped", 12'h000, {11'h000, radio_tx_valid_o});
      $display("receive done");
    end
  endtask
  task hs(input [6:0] v, input [1:0] e);
    begin
      @(posedge clock_i);
      {cts_mode_i, cd_mode_i, radio_above_thresh_i, radio_transmitting_i, radio_valid_data_i,
        radio_receiving_i} <= v;
      repeat (3) @(posedge clock_i);
      chk("cd cts", {10'h000, e}, {10'h000, cd_o, cts_o});
    end
  endtask
  task t_pause;
    begin
      hs(7'h04, 2'h3);
      tx_pause_i <= 1'b1;
      @(posedge clock_i);
      tx_pause_i <= 1'b0;
      repeat (3) @(posedge clock_i);
      chk("cts pause", 12'h000, {11'h000, cts_o});
      hs(7'h00, 2'h1);
      $display("pause done");
    end
  endtask
  task t_rts;
    reg [11:0] f;
    reg ok;
    integer i, n;
    begin
      rts_i <= 1'b0;
      out_char(9'h03c, 8, 2'h1, 1'b0, 100);
      rts_mode_i <= 2'h2;
      repeat (8) @(posedge clock_i);
      chk("abort", 12'h001, {11'h000, rx_abort_o});
      rts_i <= 1'b1;
      repeat (8) @(posedge clock_i);
      chk("abort off", 12'h000, {11'h000, rx_abort_o});
      rts_mode_i <= 2'h1;
      rts_i <= 1'b0;
      repeat (8) @(posedge clock_i);
      n = 0;
      for (i = 0; i < 17; i = i + 1) begin
        push(9'h030 + i[8:0], ok);
        n = n + ok;
      end
      chk("fifo fill", 12'h010, n[11:0]);
      chk("held", 12'h001, {11'h000, serial_tx_o});
      rts_i <= 1'b1;
      for (i = 0; i < 16; i = i + 1) begin
        term.recv(100, 11, 2000, f);
        chk("drain", frame(9'h030 + i[8:0], 8, 2'h1, 1'b0), f);
      end
      $display("rts done");
    end
  endtask
  task t_cfg;
    reg [55:0] keys;
    integer i;
    begin
      keys = {8'h65, 8'h51, 8'h41, 8'h4e, 8'h61, 8'h59, 8'h79};
      cfg_strobe_n_i <= 1'b0;
      repeat (8) @(posedge clock_i);
      chk("setup on", 12'h001, {11'h000, config_mode_o});
      for (i = 6; i >= 0; i = i - 1)
        term.send(frame({1'b0, keys[i * 8 +: 8]}, 8, 2'h0, 1'b0), 10, 400);
      repeat (20) @(posedge clock_i);
      chk("menu keys", 12'h111, n_menu);
      cfg_strobe_n_i <= 1'b1;
      repeat (8) @(posedge clock_i);
      chk("setup off", 12'h000, {11'h000, config_mode_o});
      $display("setup done");
    end
  endtask
  task summarize;
    begin
      $display("checks %0d errors %0d", cmp_count, n_errors);
      if (n_errors == 0 && cmp_count > 0)
        $display("Testbench passed");
      else
        $display("Testbench failed");
      $finish;
    end
  endtask
  initial begin
    #360000;
    n_errors = n_errors + 1;
    summarize;
  end
  initial begin
    repeat (2) @(posedge clock_i);
    chk("reset", 12'h001, {7'h00, cd_o, cts_o, rx_abort_o, config_mode_o, serial_tx_o});
    @(posedge clock_i);
    srst_i <= 1'b0;
    repeat (8) @(posedge clock_i);
    t_formats;
    t_rates;
    t_in;
    hs(7'h08, 2'h3);
    hs(7'h04, 2'h3);
    hs(7'h00, 2'h1);
    hs(7'h19, 2'h0);
    hs(7'h12, 2'h3);
    hs(7'h61, 2'h3);
    hs(7'h70, 2'h3);
    $display("handshake done");
    t_pause;
    t_rts;
    t_cfg;
    summarize;
  end
endmodule
